// >>> hdl/mfp_top.sv
// Fault supervisor: overcurrent, regulator overcurrent, rotor stall, thermal
`timescale 1ns/1ns
`include "mfp_defs.svh"

module mfp_top #(
  parameter int unsigned ST_TDET0_CYC = `MFP_MS_CYC(`MFP_ST_TDET0_MS),
  parameter int unsigned ST_TDET1_CYC = `MFP_MS_CYC(`MFP_ST_TDET1_MS),
  parameter int unsigned ST_TDET2_CYC = `MFP_MS_CYC(`MFP_ST_TDET2_MS),
  parameter int unsigned ST_TDET3_CYC = `MFP_MS_CYC(`MFP_ST_TDET3_MS),
  parameter int unsigned OC_RETRY_CYC = `MFP_MS_CYC(`MFP_OC_RETRY_MS),
  parameter int unsigned ST_RETRY_CYC = `MFP_MS_CYC(`MFP_ST_RETRY_MS),
  parameter int unsigned REG_RETRY_CYC = `MFP_MS_CYC(`MFP_REG_RETRY_MS),
  parameter int unsigned RST_MAX_CYC = `MFP_US_DN(`MFP_RST_MAX_US)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pin_config,
  input wire logic [5:0] fet_overcurrent,
  input wire logic regulator_overcurrent,
  input wire logic [2:0] hall,
  input wire logic temp_over_warning,
  input wire logic temp_over_warning_hys,
  input wire logic temp_over_fet_limit,
  input wire logic temp_over_die_limit,
  input wire logic sleep_pin_active_low,
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic [1:0] overcurrent_level_select,
  output logic fets_enable,
  output logic charge_pump_enable,
  output logic regulator_enable,
  output logic regulator_fets_enable,
  output mfp_pkg::mfp_resp_t overcurrent_response_mode
);
  import mfp_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Two-stage synchronisers; sleep and fault pins reset high so no false wake edge follows
  logic [16:0] sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 17'h14000;
      sync2_q <= 17'h14000;
    end else begin
      sync1_q <= {fault_pin_in, pin_config, sleep_pin_active_low, temp_over_die_limit,
                  temp_over_fet_limit, temp_over_warning_hys, temp_over_warning, hall,
                  regulator_overcurrent, fet_overcurrent};
      sync2_q <= sync1_q;
    end
  end
  logic [5:0] oc_s;
  logic reg_s, otw_s, otw_hys_s, tsd_fet_s, tsd_die_s, sleep_n_s, pin_cfg_s, pin_s;
  logic [2:0] hall_s;
  assign oc_s = sync2_q[5:0];
  assign reg_s = sync2_q[6];
  assign hall_s = sync2_q[9:7];
  assign otw_s = sync2_q[10];
  assign otw_hys_s = sync2_q[11];
  assign tsd_fet_s = sync2_q[12];
  assign tsd_die_s = sync2_q[13];
  assign sleep_n_s = sync2_q[14];
  assign pin_cfg_s = sync2_q[15];
  assign pin_s = sync2_q[16];

  // Avalon slave: one wait cycle, answer registered
  logic ack_q, wr_acc;
  logic [11:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [31:0] chip_stat, stat1;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_acc = avs_write & ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        `MFP_CTRL_OFS: rdata_q <= {20'h00000, ctrl_q};
        `MFP_CHIP_STAT_OFS: rdata_q <= chip_stat;
        `MFP_STAT1_OFS: rdata_q <= stat1;
        `MFP_PINS_OFS: rdata_q <= {30'h00000000, pin_cfg_s, pin_s};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Clear bit is a strobe and never stored
  logic clr_wr;
  assign clr_wr = wr_acc && avs_address == `MFP_CTRL_OFS && avs_byteenable[1]
                  && avs_writedata[`MFP_CTRL_CLR_BIT];
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `MFP_CTRL_RESET;
    end else if (wr_acc && avs_address == `MFP_CTRL_OFS) begin
      if (avs_byteenable[0]) begin
        ctrl_q[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ctrl_q[8] <= avs_writedata[8];
        ctrl_q[11:10] <= avs_writedata[11:10];
      end
    end
  end

  // Effective configuration: pin parts ignore the control fields
  mfp_resp_t oc_mode, st_mode;
  logic [1:0] oc_deg_sel, st_tdet_sel;
  logic thermal_warning_report_enable;
  always_comb begin
    oc_mode = pin_cfg_s ? MFP_RESP_LATCH : mfp_resp_t'(ctrl_q[1:0]);
    oc_deg_sel = pin_cfg_s ? `MFP_PIN_OC_DEG_SEL : ctrl_q[7:6];
    overcurrent_level_select = pin_cfg_s ? `MFP_PIN_OC_LVL : ctrl_q[11:10];
    st_mode = pin_cfg_s ? MFP_RESP_LATCH : mfp_resp_t'(ctrl_q[3:2]);
    st_tdet_sel = pin_cfg_s ? `MFP_PIN_ST_TDET_SEL : ctrl_q[5:4];
    thermal_warning_report_enable = ~pin_cfg_s & ctrl_q[`MFP_CTRL_THERMAL_WARNING_REPORT_ENABLE_BIT];
  end
  assign overcurrent_response_mode = oc_mode;

  function automatic logic [11:0] deg_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: deg_cyc = 12'(`MFP_NS_UP(`MFP_OC_DEG0_NS));
      2'h1: deg_cyc = 12'(`MFP_NS_UP(`MFP_OC_DEG1_NS));
      2'h2: deg_cyc = 12'(`MFP_NS_UP(`MFP_OC_DEG2_NS));
      default: deg_cyc = 12'(`MFP_NS_UP(`MFP_OC_DEG3_NS));
    endcase
  endfunction

  function automatic logic [31:0] tdet_cyc(input logic [1:0] sel);
    case (sel)
      2'h0: tdet_cyc = ST_TDET0_CYC;
      2'h1: tdet_cyc = ST_TDET1_CYC;
      2'h2: tdet_cyc = ST_TDET2_CYC;
      default: tdet_cyc = ST_TDET3_CYC;
    endcase
  endfunction

  // Sleep pin: short low pulse clears faults, long low is sleep
  logic sleep_prev_q, sleeping_q, rst_pulse, clr;
  logic [31:0] low_cnt_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_prev_q <= 1'b1;
      low_cnt_q <= 32'h00000000;
      sleeping_q <= 1'b0;
    end else begin
      sleep_prev_q <= sleep_n_s;
      if (sleep_n_s) begin
        low_cnt_q <= 32'h00000000;
        sleeping_q <= 1'b0;
      end else if (low_cnt_q <= RST_MAX_CYC) begin
        low_cnt_q <= low_cnt_q + 32'h00000001;
      end else begin
        sleeping_q <= 1'b1;
      end
    end
  end
  assign rst_pulse = sleep_n_s & ~sleep_prev_q & (low_cnt_q <= RST_MAX_CYC);
  // Sleep also wipes the flags, as a wake-up starts from defaults
  assign clr = clr_wr | rst_pulse | sleeping_q;

  // Phase overcurrent deglitch per FET
  logic [11:0] oc_cnt_q [6];
  logic [5:0] oc_trip;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (reset || !oc_s[i]) begin
        oc_cnt_q[i] <= 12'h000;
      end else if (oc_cnt_q[i] < deg_cyc(oc_deg_sel)) begin
        oc_cnt_q[i] <= oc_cnt_q[i] + 12'h001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      oc_trip[i] = oc_s[i] && oc_cnt_q[i] >= deg_cyc(oc_deg_sel);
    end
  end

  // Phase overcurrent response
  mfp_prot_state_t oc_state_q;
  logic [31:0] oc_tmr_q;
  logic oc_clr_seen_q, oc_flag_q, oc_report_q;
  logic [5:0] fet_flag_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_state_q <= MFP_RUN;
      oc_tmr_q <= 32'h00000000;
      oc_clr_seen_q <= 1'b0;
    end else begin
      case (oc_state_q)
        MFP_RUN: begin
          oc_clr_seen_q <= 1'b0;
          oc_tmr_q <= 32'h00000000;
          if (|oc_trip && oc_mode == MFP_RESP_LATCH) begin
            oc_state_q <= MFP_LATCHED;
          end else if (|oc_trip && oc_mode == MFP_RESP_RETRY) begin
            oc_state_q <= MFP_RETRY;
          end
        end
        MFP_LATCHED: begin
          if ((oc_clr_seen_q || clr) && !(|oc_s)) begin
            oc_state_q <= MFP_RUN;
          end else if (clr) begin
            oc_clr_seen_q <= 1'b1;
          end
        end
        MFP_RETRY: begin
          if (oc_tmr_q >= OC_RETRY_CYC - 1) begin
            oc_state_q <= MFP_RUN;
          end else begin
            oc_tmr_q <= oc_tmr_q + 32'h00000001;
          end
        end
        default: oc_state_q <= MFP_RUN;
      endcase
    end
  end

  // Overcurrent flags: set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_flag_q <= 1'b0;
      fet_flag_q <= 6'h00;
      oc_report_q <= 1'b0;
    end else begin
      if (oc_mode != MFP_RESP_OFF) begin
        oc_flag_q <= |oc_trip | (oc_flag_q & ~clr);
        fet_flag_q <= oc_trip | (fet_flag_q & ~{6{clr}});
      end else begin
        oc_flag_q <= oc_flag_q & ~clr;
        fet_flag_q <= fet_flag_q & ~{6{clr}};
      end
      oc_report_q <= (|oc_trip && oc_mode == MFP_RESP_REPORT) | (oc_report_q & ~clr);
    end
  end

  // Regulator overcurrent: deglitch, then fixed retry
  logic [11:0] reg_cnt_q;
  logic [31:0] reg_tmr_q;
  logic reg_trip, reg_retry_q, reg_fault_q, reg_oc_q;
  assign reg_trip = reg_s && reg_cnt_q >= 12'(`MFP_NS_UP(`MFP_REG_DEG_NS));
  always_ff @(posedge clk) begin
    if (reset || !reg_s) begin
      reg_cnt_q <= 12'h000;
    end else if (!reg_trip) begin
      reg_cnt_q <= reg_cnt_q + 12'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_retry_q <= 1'b0;
      reg_tmr_q <= 32'h00000000;
      reg_fault_q <= 1'b0;
      reg_oc_q <= 1'b0;
    end else if (!reg_retry_q) begin
      reg_tmr_q <= 32'h00000000;
      if (reg_trip) begin
        reg_retry_q <= 1'b1;
        reg_fault_q <= 1'b1;
        reg_oc_q <= 1'b1;
      end
    end else if (reg_tmr_q >= REG_RETRY_CYC - 1) begin
      reg_retry_q <= 1'b0;
      reg_fault_q <= 1'b0;
      reg_oc_q <= 1'b0;
    end else begin
      reg_tmr_q <= reg_tmr_q + 32'h00000001;
    end
  end

  // Rotor stall: one counter times detection in run and the retry wait
  logic [2:0] hall_prev_q;
  logic hall_edge, st_trip, st_flag_q;
  mfp_prot_state_t st_state_q;
  logic [31:0] st_cnt_q;
  assign hall_edge = hall_s != hall_prev_q;
  assign st_trip = st_state_q == MFP_RUN && st_mode != MFP_RESP_OFF
                   && st_cnt_q >= tdet_cyc(st_tdet_sel);
  always_ff @(posedge clk) begin
    if (reset) begin
      hall_prev_q <= 3'h0;
      st_state_q <= MFP_RUN;
      st_cnt_q <= 32'h00000000;
    end else begin
      hall_prev_q <= hall_s;
      case (st_state_q)
        MFP_RUN: begin
          if (hall_edge || st_mode == MFP_RESP_OFF) begin
            st_cnt_q <= 32'h00000000;
          end else if (!st_trip) begin
            st_cnt_q <= st_cnt_q + 32'h00000001;
          end else if (st_mode == MFP_RESP_LATCH) begin
            st_state_q <= MFP_LATCHED;
          end else if (st_mode == MFP_RESP_RETRY) begin
            st_state_q <= MFP_RETRY;
            st_cnt_q <= 32'h00000000;
          end
        end
        MFP_LATCHED: begin
          st_cnt_q <= 32'h00000000;
          if (clr) begin
            st_state_q <= MFP_RUN;
          end
        end
        MFP_RETRY: begin
          if (st_cnt_q >= ST_RETRY_CYC - 1) begin
            st_state_q <= MFP_RUN;
            st_cnt_q <= 32'h00000000;
          end else begin
            st_cnt_q <= st_cnt_q + 32'h00000001;
          end
        end
        default: st_state_q <= MFP_RUN;
      endcase
    end
  end
  // Report mode keeps driving; flag alone holds the pin low until clear
  always_ff @(posedge clk) begin
    if (reset) begin
      st_flag_q <= 1'b0;
    end else if (st_trip) begin
      st_flag_q <= 1'b1;
    end else if (st_state_q == MFP_RETRY && st_cnt_q >= ST_RETRY_CYC - 1) begin
      st_flag_q <= 1'b0;
    end else if (clr && st_state_q != MFP_RETRY) begin
      st_flag_q <= 1'b0;
    end
  end

  // Thermal warning and shutdown flags
  logic otw_flag_q, ot_flag_q, ots_flag_q, otw_pin_q, tsd_any;
  assign tsd_any = tsd_fet_s | tsd_die_s;
  always_ff @(posedge clk) begin
    if (reset) begin
      otw_flag_q <= 1'b0;
      ot_flag_q <= 1'b0;
      ots_flag_q <= 1'b0;
      otw_pin_q <= 1'b0;
    end else begin
      otw_flag_q <= otw_s | (otw_flag_q & ~clr);
      ot_flag_q <= otw_s | tsd_any | (ot_flag_q & ~clr);
      ots_flag_q <= tsd_any | (ots_flag_q & ~clr);
      if (otw_s && thermal_warning_report_enable) begin
        otw_pin_q <= 1'b1;
      end else if (!otw_hys_s || !thermal_warning_report_enable) begin
        otw_pin_q <= 1'b0;
      end
    end
  end

  // Status views; global fault summarises every reported flag
  logic global_fault;
  assign global_fault = oc_flag_q | oc_report_q | reg_fault_q | st_flag_q | ots_flag_q
                        | (otw_flag_q & thermal_warning_report_enable);
  always_comb begin
    chip_stat = 32'h00000000;
    chip_stat[`MFP_CS_FAULT_BIT] = global_fault;
    chip_stat[`MFP_CS_OT_BIT] = ot_flag_q;
    chip_stat[`MFP_CS_OC_BIT] = oc_flag_q;
    chip_stat[`MFP_CS_REG_FLT_BIT] = reg_fault_q;
    chip_stat[`MFP_CS_STALL_BIT] = st_flag_q;
    stat1 = 32'h00000000;
    stat1[`MFP_S1_FET_LSB +: 6] = fet_flag_q;
    stat1[`MFP_S1_OTW_BIT] = otw_flag_q;
    stat1[`MFP_S1_OTS_BIT] = ots_flag_q;
    stat1[`MFP_S1_REG_OC_BIT] = reg_oc_q;
  end

  // Power stage enables and fault pin, registered to keep them glitch free
  logic fets_en_q, cp_en_q, reg_en_q, reg_fets_en_q, fault_drive_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      fets_en_q <= 1'b0;
      cp_en_q <= 1'b0;
      reg_en_q <= 1'b0;
      reg_fets_en_q <= 1'b0;
      fault_drive_q <= 1'b0;
    end else begin
      fets_en_q <= oc_state_q == MFP_RUN && st_state_q == MFP_RUN && !tsd_any
                   && !sleeping_q;
      cp_en_q <= !tsd_any && !sleeping_q;
      reg_en_q <= !tsd_die_s && !sleeping_q;
      reg_fets_en_q <= !reg_retry_q && !tsd_die_s && !sleeping_q;
      fault_drive_q <= oc_state_q != MFP_RUN || oc_report_q || reg_retry_q
                       || st_state_q != MFP_RUN || st_flag_q || otw_pin_q
                       || tsd_any;
    end
  end
  assign fets_enable = fets_en_q;
  assign charge_pump_enable = cp_en_q;
  assign regulator_enable = reg_en_q;
  assign regulator_fets_enable = reg_fets_en_q;
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe = fault_drive_q;

  property p_oc_latch;
    oc_state_q == MFP_RUN && |oc_trip && oc_mode == MFP_RESP_LATCH
      |-> ##2 !fets_enable && fault_pin_oe && oc_flag_q;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("latched overcurrent not applied");

  property p_oc_hold;
    oc_state_q == MFP_LATCHED && !oc_clr_seen_q && !clr |=> oc_state_q == MFP_LATCHED;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("latched overcurrent left early");

  property p_oc_retry;
    oc_state_q == MFP_RUN ##1 oc_state_q == MFP_RETRY |=> (oc_state_q == MFP_RETRY
      && !fets_enable)[*8];
  endproperty
  a_oc_retry: assert property (p_oc_retry) else $error("overcurrent retry too short");

  property p_oc_flag;
    oc_flag_q && !clr |=> oc_flag_q;
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag lost");

  property p_reg;
    reg_trip && !reg_retry_q |=> reg_retry_q && reg_oc_q ##1 !regulator_fets_enable;
  endproperty
  a_reg: assert property (p_reg) else $error("regulator retry not entered");

  property p_st_latch;
    st_state_q == MFP_LATCHED && !clr |=> st_state_q == MFP_LATCHED && st_flag_q;
  endproperty
  a_st_latch: assert property (p_st_latch) else $error("stall latch released early");

  property p_st_off;
    st_mode == MFP_RESP_OFF && !st_flag_q |=> !st_flag_q;
  endproperty
  a_st_off: assert property (p_st_off) else $error("disabled stall reported");

  property p_tsd;
    tsd_die_s |=> !regulator_enable && !charge_pump_enable ##1 ots_flag_q;
  endproperty
  a_tsd: assert property (p_tsd) else $error("die shutdown not applied");

  property p_ots;
    ots_flag_q && !clr |=> ots_flag_q;
  endproperty
  a_ots: assert property (p_ots) else $error("thermal shutdown flag lost");

  property p_otw;
    otw_flag_q && (!clr || otw_s) |=> otw_flag_q;
  endproperty
  a_otw: assert property (p_otw) else $error("warning flag cleared while hot");
endmodule

// >>> shared/mfp_defs.svh
// Offsets, field positions, reset values and timing figures of the fault supervisor
`ifndef MFP_DEFS_SVH
`define MFP_DEFS_SVH

`define MFP_CLK_MHZ 250

// Register byte offsets
`define MFP_CTRL_OFS 4'h0
`define MFP_CHIP_STAT_OFS 4'h4
`define MFP_STAT1_OFS 4'h8
`define MFP_PINS_OFS 4'hc

// Control register fields
`define MFP_CTRL_OC_MODE_LSB 0
`define MFP_CTRL_ST_MODE_LSB 2
`define MFP_CTRL_ST_TDET_LSB 4
`define MFP_CTRL_OC_DEG_LSB 6
`define MFP_CTRL_THERMAL_WARNING_REPORT_ENABLE_BIT 8
`define MFP_CTRL_CLR_BIT 9
`define MFP_CTRL_OC_LVL_LSB 10
`define MFP_CTRL_RESET 12'h000

// Chip status fields
`define MFP_CS_FAULT_BIT 0
`define MFP_CS_OT_BIT 3
`define MFP_CS_OC_BIT 4
`define MFP_CS_REG_FLT_BIT 6
`define MFP_CS_STALL_BIT 7

// Status 1 fields
`define MFP_S1_FET_LSB 0
`define MFP_S1_OTW_BIT 6
`define MFP_S1_OTS_BIT 7
`define MFP_S1_REG_OC_BIT 8

// Fixed settings of the pin-configured variant
`define MFP_PIN_OC_DEG_SEL 2'h1
`define MFP_PIN_OC_LVL 2'h3
`define MFP_PIN_ST_TDET_SEL 2'h2

// Times in their own units
`define MFP_OC_DEG0_NS 200
`define MFP_OC_DEG1_NS 600
`define MFP_OC_DEG2_NS 1200
`define MFP_OC_DEG3_NS 1800
`define MFP_REG_DEG_NS 1000
`define MFP_ST_TDET0_MS 300
`define MFP_ST_TDET1_MS 500
`define MFP_ST_TDET2_MS 1000
`define MFP_ST_TDET3_MS 5000
`define MFP_OC_RETRY_MS 5
`define MFP_ST_RETRY_MS 5000
`define MFP_REG_RETRY_MS 1
`define MFP_RST_MAX_US 20

// Least times round up, longest times round down
`define MFP_NS_UP(ns) (((ns) * `MFP_CLK_MHZ + 999) / 1000)
`define MFP_MS_CYC(ms) ((ms) * `MFP_CLK_MHZ * 1000)
`define MFP_US_DN(us) ((us) * `MFP_CLK_MHZ)

`endif

// >>> shared/mfp_pkg.sv
// Types of the fault supervisor
package mfp_pkg;
  typedef enum logic [1:0] {
    MFP_RESP_LATCH,
    MFP_RESP_RETRY,
    MFP_RESP_REPORT,
    MFP_RESP_OFF
  } mfp_resp_t;

  typedef enum logic [1:0] {
    MFP_RUN,
    MFP_LATCHED,
    MFP_RETRY
  } mfp_prot_state_t;
endpackage

// >>> tb/mfp_ctrl_model.sv
// Far-side controller: turns the Hall inputs, pulses sleep to clear, pulls the fault wire up
`timescale 1ns/1ns
module mfp_ctrl_model (
  input wire logic clk,
  input wire logic fault_pin_oe,
  input wire logic spin,
  input wire logic clear_req,
  output logic [2:0] hall,
  output logic sleep_pin_active_low,
  output logic fault_wire
);
  logic [3:0] tick_q = 4'h0;
  logic [3:0] low_q = 4'h0;
  // Open drain with a pull-up, so a released wire reads high
  assign fault_wire = !fault_pin_oe;
  initial hall = 3'h1;
  initial sleep_pin_active_low = 1'b1;
  always @(posedge clk) begin
    tick_q <= tick_q + 4'h1;
    // Gaps of 16 cycles stay far below the stall detect time
    if (spin && tick_q == 4'hf) begin
      hall <= {hall[1:0], ~hall[2]};
    end
    if (clear_req) begin
      low_q <= 4'h8;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
    sleep_pin_active_low <= low_q == 4'h0 && !clear_req;
  end
endmodule

// >>> tb/motor_driver_fault_protection_test.sv
// Self-checking bench of the fault supervisor
`timescale 1ns/1ns
module motor_driver_fault_protection_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] ad = 4'h0;
  logic [3:0] be = 4'hf;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rq;
  logic [31:0] rdq;
  logic wt;
  logic [5:0] fet_oc = 6'h0;
  logic reg_oc = 1'b0, fet_hot = 1'b0, die_hot = 1'b0, spin = 1'b1, clear_req = 1'b0;
  logic thermal_warning_flag = 1'b0, otw_hys = 1'b0, pin_cfg = 1'b0;
  logic [1:0] oc_lvl, oc_resp;
  logic [2:0] hall;
  logic sleep_pin_active_low, fault_wire, fault_pin_oe, fets_en, cp_en, reg_en, regf_en;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  wire [4:0] pins = {fets_en, cp_en, reg_en, regf_en, fault_pin_oe};
  // Pins per response mode 0..3
  localparam logic [4:0] hit [4] = '{5'h0f, 5'h0f, 5'h1f, 5'h1e};
  localparam logic [4:0] hold [4] = '{5'h0f, 5'h1e, 5'h1f, 5'h1e};
  mfp_top #(.ST_TDET0_CYC(200), .OC_RETRY_CYC(50), .ST_RETRY_CYC(60), .REG_RETRY_CYC(40)) DUT (
    .clk(clk), .reset(reset), .avs_address(ad), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rq), .avs_waitrequest(wt),
    .pin_config(pin_cfg), .fet_overcurrent(fet_oc), .regulator_overcurrent(reg_oc), .hall(hall),
    .temp_over_warning(thermal_warning_flag), .temp_over_warning_hys(otw_hys), .temp_over_fet_limit(fet_hot),
    .temp_over_die_limit(die_hot), .sleep_pin_active_low(sleep_pin_active_low),
    .fault_pin_in(fault_wire), .fault_pin_out(), .fault_pin_oe(fault_pin_oe),
    .overcurrent_level_select(oc_lvl), .fets_enable(fets_en), .charge_pump_enable(cp_en),
    .regulator_enable(reg_en), .regulator_fets_enable(regf_en),
    .overcurrent_response_mode(oc_resp));
  mfp_ctrl_model ctrl (.clk(clk), .fault_pin_oe(fault_pin_oe), .spin(spin),
    .clear_req(clear_req), .hall(hall), .sleep_pin_active_low(sleep_pin_active_low),
    .fault_wire(fault_wire));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request stays put until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wt !== 1'b0);
    rdq = rq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rdq, e);
  endtask
  task automatic chk_pins(input logic [4:0] e, input logic [4:0] k = 5'h1f);
    @(negedge clk);
    cmp({27'h0, pins & k}, {27'h0, e});
    @(posedge clk);
  endtask
  // Threshold code above, response mode below
  task automatic chk_cfg(input logic [3:0] e);
    @(negedge clk);
    cmp({28'h0, oc_lvl, oc_resp}, {28'h0, e});
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(8);
    reset <= 1'b0;
    cyc(4);
    chk_pins(5'h1e);
    chk_reg(4'hc, 32'h1);
    bus(1'b1, 4'h0, 32'hffff_ffff);
    chk_reg(4'h0, 32'hdff);
    chk_cfg(4'hf);
    be <= 4'h2;
    bus(1'b1, 4'h0, 32'h0);
    be <= 4'hf;
    chk_reg(4'h0, 32'h0ff);
    chk_cfg(4'h3);
    bus(1'b1, 4'h4, 32'hffff_ffff);
    chk_reg(4'h4, 32'h0);
    chk_reg(4'h2, 32'h0);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 4'h0, 32'(m));
      fet_oc <= 6'h04;
      cyc(30);
      fet_oc <= 6'h00;
      cyc(10);
      chk_pins(5'h1e);
      fet_oc <= 6'h04;
      cyc(60);
      chk_pins(hit[m]);
      fet_oc <= 6'h00;
      cyc(60);
      chk_pins(hold[m]);
      chk_reg(4'h8, m == 3 ? 32'h0 : 32'h4);
      chk_reg(4'h4, m == 3 ? 32'h0 : 32'h11);
      bus(1'b1, 4'h0, 32'(m) | 32'h200);
      cyc(8);
      chk_pins(5'h1e);
      chk_reg(4'h4, 32'h0);
    end
    $display("test overcurrent done");
    reg_oc <= 1'b1;
    cyc(240);
    chk_pins(5'h1e);
    cyc(20);
    chk_pins(5'h1d);
    reg_oc <= 1'b0;
    chk_reg(4'h4, 32'h41);
    chk_reg(4'h8, 32'h100);
    cyc(40);
    chk_pins(5'h1e);
    chk_reg(4'h4, 32'h0);
    $display("test regulator done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 4'h0, 32'(m) << 2);
      spin <= 1'b0;
      cyc(240);
      chk_pins(hit[m]);
      chk_reg(4'h4, m == 3 ? 32'h0 : 32'h81);
      spin <= 1'b1;
      cyc(20);
      bus(1'b1, 4'h0, (32'(m) << 2) | 32'h200);
      cyc(80);
      chk_pins(5'h1e);
    end
    $display("test stall done");
    fet_hot <= 1'b1;
    cyc(6);
    chk_pins(5'h07);
    fet_hot <= 1'b0;
    die_hot <= 1'b1;
    cyc(6);
    chk_pins(5'h01, 5'h1d);
    die_hot <= 1'b0;
    cyc(6);
    chk_pins(5'h1e);
    chk_reg(4'h8, 32'h80);
    clear_req <= 1'b1;
    cyc(1);
    clear_req <= 1'b0;
    cyc(20);
    chk_reg(4'h8, 32'h0);
    bus(1'b1, 4'h0, 32'h100);
    thermal_warning_flag <= 1'b1;
    otw_hys <= 1'b1;
    cyc(6);
    chk_pins(5'h1f);
    chk_reg(4'h8, 32'h40);
    chk_reg(4'h4, 32'h9);
    bus(1'b1, 4'h0, 32'h300);
    chk_reg(4'h8, 32'h40);
    thermal_warning_flag <= 1'b0;
    cyc(6);
    chk_pins(5'h1f);
    otw_hys <= 1'b0;
    cyc(6);
    chk_pins(5'h1e);
    chk_reg(4'h8, 32'h40);
    bus(1'b1, 4'h0, 32'h300);
    chk_reg(4'h8, 32'h0);
    $display("test thermal done");
    // Control asks for retry with short deglitch; the strap must override both
    bus(1'b1, 4'h0, 32'h1);
    pin_cfg <= 1'b1;
    cyc(4);
    chk_cfg(4'hc);
    chk_reg(4'hc, 32'h3);
    fet_oc <= 6'h01;
    cyc(100);
    fet_oc <= 6'h00;
    cyc(4);
    chk_pins(5'h1e);
    fet_oc <= 6'h01;
    cyc(170);
    fet_oc <= 6'h00;
    cyc(70);
    chk_pins(5'h0f);
    chk_reg(4'h8, 32'h1);
    bus(1'b1, 4'h0, 32'h201);
    cyc(8);
    chk_pins(5'h1e);
    pin_cfg <= 1'b0;
    $display("test pin variant done");
    tally_and_finish();
  end
endmodule
